// [pkg/aocr_pkg.sv]
// Constants, types and register map for the output configuration bank
package aocr_pkg;

  // Register addresses on the serial configuration port
  localparam logic [12:0] ADDR_DEV_INDEX  = 13'h0005;
  localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
  localparam logic [12:0] ADDR_CLK_DIV    = 13'h000B;
  localparam logic [12:0] ADDR_OUT_MODE   = 13'h0014;
  localparam logic [12:0] ADDR_OUT_ADJUST = 13'h0015;
  localparam logic [12:0] ADDR_OUT_PHASE  = 13'h0016;
  localparam logic [12:0] ADDR_TRANSFER   = 13'h00FF;
  localparam logic [12:0] ADDR_OVERRIDE   = 13'h0100;
  localparam logic [12:0] ADDR_USER_IO2   = 13'h0101;
  localparam logic [12:0] ADDR_USER_IO3   = 13'h0102;

  // Reset values
  localparam logic [7:0] RST_DEV_INDEX  = 8'h0F;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_OUT_MODE   = 8'h01;
  localparam logic [7:0] RST_OUT_PHASE  = 8'h03;

  // Field positions
  localparam int DI_FCO_BIT     = 4;
  localparam int DI_DCO_BIT     = 5;
  localparam int OM_INVERT_BIT  = 2;
  localparam int OM_FORMAT_BIT  = 0;
  localparam int OA_TERM_LSB    = 4;
  localparam int OA_DRIVE_BIT   = 0;
  localparam int OP_CLKPH_LSB   = 4;
  localparam int OP_DCOPH_LSB   = 0;
  localparam int CD_RATIO_LSB   = 0;
  localparam int OV_EN_BIT      = 6;
  localparam int OV_RES_LSB     = 4;
  localparam int OV_RATE_LSB    = 0;
  localparam int IO2_PD_BIT     = 0;
  localparam int IO3_VCM_BIT    = 3;
  localparam int XFER_BIT       = 0;
  localparam int PM_MODE_LSB    = 0;

  // Field values
  localparam logic [3:0] DCO_CODE_MAX  = 4'hB;
  localparam logic [3:0] DCO_CODE_DFLT = 4'h3;
  localparam logic [1:0] RES_12_BITS   = 2'h2;
  localparam logic [1:0] RES_10_BITS   = 2'h3;
  localparam logic [2:0] RATE_GRADE    = 3'h4;

  // Serial port framing
  localparam logic [4:0] SPI_INSTR_LAST = 5'h0F;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h10;
  localparam logic [4:0] SPI_WORD_LAST  = 5'h17;

  // Timing of the power-up initialisation
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYCLES   =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Internal power mode field
  typedef enum logic [1:0] {
    PM_NORMAL    = 2'b00,
    PM_POWERDOWN = 2'b01,
    PM_STANDBY   = 2'b10,
    PM_DIGRESET  = 2'b11
  } aocr_pwr_e;

  // Initialisation sequencer
  typedef enum logic [0:0] {
    INIT_RUN  = 1'b0,
    INIT_DONE = 1'b1
  } aocr_init_e;

  // Serial pins as sampled together
  typedef struct packed {
    logic sclk;
    logic csb_n;
    logic sdio;
  } aocr_pins_s;

  // Resolution and sample-rate override fields
  typedef struct packed {
    logic       enable;
    logic [1:0] res;
    logic [2:0] rate;
  } aocr_override_s;

endpackage

// [core/aocr_config_regs.sv]
// Output configuration registers with serial port and output data path
`timescale 1ns/1ps
module aocr_config_regs #(
  parameter int         DATA_W     = 12,
  parameter logic [2:0] SPEED_RATE = aocr_pkg::RATE_GRADE
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Serial configuration port
  input  wire logic              spi_sclk,
  input  wire logic              spi_csb_n,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe_n,
  // Converter samples in (offset binary)
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic              sample_valid,
  // Formatted samples out
  output logic      [DATA_W-1:0] out_data,
  output logic                   out_valid,
  output logic                   sample_strobe,
  // Output driver and clock controls
  output logic      [1:0]        term_sel,
  output logic                   fco_drive_2x,
  output logic                   dco_drive_2x,
  output logic      [3:0]        dco_phase_code,
  // Pad and reference controls
  output logic                   sdio_pulldown_en,
  output logic                   vcm_powerdown,
  // Applied override and power state
  output logic                   res_10bit,
  output logic      [2:0]        rate_code,
  output logic                   chip_powerdown,
  output logic                   datapath_reset,
  output logic                   datapath_clk_en,
  output logic                   init_done
);

  // Pin synchronisers: three stages, then an agreed level
  aocr_pkg::aocr_pins_s pin_s1;        // First stage, read by second only
  aocr_pkg::aocr_pins_s pin_s2;        // Second stage
  aocr_pkg::aocr_pins_s pin_s3;        // Third stage
  aocr_pkg::aocr_pins_s pin_lvl;       // Level accepted once s2 and s3 agree
  aocr_pkg::aocr_pins_s next_pin_lvl;

  // Serial port state
  logic [4:0]  bit_cnt,   next_bit_cnt;    // Bit position in the frame
  logic [14:0] instr_sh,  next_instr_sh;   // Instruction shift register
  logic [12:0] spi_addr,  next_spi_addr;   // Current register address
  logic        spi_rd,    next_spi_rd;     // Frame is a read
  logic [6:0]  data_sh,   next_data_sh;    // Write data shift register
  logic        wr_stb,    next_wr_stb;     // One-cycle write strobe
  logic [12:0] wr_addr,   next_wr_addr;
  logic [7:0]  wr_byte,   next_wr_byte;
  logic        next_sdio_out;
  logic        next_sdio_oe_n;

  // Register file
  logic [7:0]  dev_index, next_dev_index;
  logic [1:0]  pwr_mode,  next_pwr_mode;
  logic [2:0]  div_ratio, next_div_ratio;
  logic [7:0]  out_mode,  next_out_mode;
  logic [7:0]  out_adj,   next_out_adj;
  logic [7:0]  out_phase, next_out_phase;
  logic [7:0]  ovr_shadow, next_ovr_shadow;  // Written, not yet applied
  aocr_pkg::aocr_override_s ovr_act, next_ovr_act; // Applied override
  logic [7:0]  io_ctl2,   next_io_ctl2;
  logic [7:0]  io_ctl3,   next_io_ctl3;
  logic        fco_drv,   next_fco_drv;    // Per-clock drive request
  logic        dco_drv,   next_dco_drv;

  // Initialisation and data path
  aocr_pkg::aocr_init_e init_st, next_init_st;
  logic [6:0]  init_cnt,  next_init_cnt;
  logic [2:0]  div_cnt,   next_div_cnt;    // Input clock divider phase
  logic [DATA_W-1:0] next_out_data;
  logic        next_out_valid;
  logic        next_strobe;

  // Read multiplexer; open and unmapped locations read zero
  function automatic logic [7:0] read_reg(input logic [12:0] a);
    case (a)
      aocr_pkg::ADDR_DEV_INDEX:  read_reg = dev_index;
      aocr_pkg::ADDR_POWER_MODE: read_reg = {6'h00, pwr_mode};
      aocr_pkg::ADDR_CLK_DIV:    read_reg = {5'h00, div_ratio};
      aocr_pkg::ADDR_OUT_MODE:   read_reg = out_mode;
      aocr_pkg::ADDR_OUT_ADJUST: read_reg = out_adj;
      aocr_pkg::ADDR_OUT_PHASE:  read_reg = out_phase;
      aocr_pkg::ADDR_OVERRIDE:   read_reg = ovr_shadow;
      aocr_pkg::ADDR_USER_IO2:   read_reg = io_ctl2;
      aocr_pkg::ADDR_USER_IO3:   read_reg = io_ctl3;
      default:                   read_reg = 8'h00;
    endcase
  endfunction

  // Agreed levels and edges of the serial pins
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic [7:0] rd_byte;  // Byte being read out
  assign rd_byte   = read_reg(spi_addr);
  assign sclk_rise = next_pin_lvl.sclk & ~pin_lvl.sclk;
  assign sclk_fall = ~next_pin_lvl.sclk & pin_lvl.sclk;
  assign cs_active = ~next_pin_lvl.csb_n;

  // Accept each pin level only when stages two and three agree
  always_comb begin
    next_pin_lvl = pin_lvl;
    if (pin_s2.sclk == pin_s3.sclk) next_pin_lvl.sclk = pin_s3.sclk;
    if (pin_s2.csb_n == pin_s3.csb_n) next_pin_lvl.csb_n = pin_s3.csb_n;
    if (pin_s2.sdio == pin_s3.sdio) next_pin_lvl.sdio = pin_s3.sdio;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_s1  <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
      pin_s2  <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
      pin_s3  <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
      pin_lvl <= '{sclk: 1'b0, csb_n: 1'b1, sdio: 1'b0};
    end else begin
      pin_s1  <= '{sclk: spi_sclk, csb_n: spi_csb_n, sdio: sdio_in};
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  // Serial frame: 16-bit instruction, then bytes with rising address
  always_comb begin
    next_bit_cnt   = bit_cnt;
    next_instr_sh  = instr_sh;
    next_spi_addr  = spi_addr;
    next_spi_rd    = spi_rd;
    next_data_sh   = data_sh;
    next_wr_stb    = 1'b0;
    next_wr_addr   = wr_addr;
    next_wr_byte   = wr_byte;
    next_sdio_out  = sdio_out;
    next_sdio_oe_n = sdio_oe_n;
    if (!cs_active) begin
      // Deselect aborts any partial frame and releases the pin
      next_bit_cnt   = 5'h00;
      next_sdio_oe_n = 1'b1;
    end else if (sclk_rise) begin
      if (bit_cnt < aocr_pkg::SPI_DATA_FIRST) begin
        next_instr_sh = {instr_sh[13:0], pin_lvl.sdio};
        if (bit_cnt == aocr_pkg::SPI_INSTR_LAST) begin
          next_spi_rd   = instr_sh[14];
          next_spi_addr = {instr_sh[11:0], pin_lvl.sdio};
        end
        next_bit_cnt = bit_cnt + 5'h01;
      end else begin
        next_data_sh = {data_sh[5:0], pin_lvl.sdio};
        if (bit_cnt == aocr_pkg::SPI_WORD_LAST) begin
          // Byte complete: write it unless the frame is a read, and step to the next address
          next_wr_stb   = ~spi_rd;
          next_wr_addr  = spi_addr;
          next_wr_byte  = {data_sh, pin_lvl.sdio};
          next_spi_addr = spi_addr + 13'h0001;
          next_bit_cnt  = aocr_pkg::SPI_DATA_FIRST;
        end else begin
          next_bit_cnt = bit_cnt + 5'h01;
        end
      end
    end else if (sclk_fall && spi_rd &&
                 bit_cnt >= aocr_pkg::SPI_DATA_FIRST) begin
      // Read data leaves MSB first on falling edges
      next_sdio_out  = rd_byte[~bit_cnt[2:0]];
      next_sdio_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bit_cnt   <= 5'h00;
      instr_sh  <= 15'h0000;
      spi_addr  <= 13'h0000;
      spi_rd    <= 1'b0;
      data_sh   <= 7'h00;
      wr_stb    <= 1'b0;
      wr_addr   <= 13'h0000;
      wr_byte   <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else begin
      bit_cnt   <= next_bit_cnt;
      instr_sh  <= next_instr_sh;
      spi_addr  <= next_spi_addr;
      spi_rd    <= next_spi_rd;
      data_sh   <= next_data_sh;
      wr_stb    <= next_wr_stb;
      wr_addr   <= next_wr_addr;
      wr_byte   <= next_wr_byte;
      sdio_out  <= next_sdio_out;
      sdio_oe_n <= next_sdio_oe_n;
    end
  end

  // Register writes; the port itself is never reset by power modes
  always_comb begin
    next_dev_index  = dev_index;
    next_pwr_mode   = pwr_mode;
    next_div_ratio  = div_ratio;
    next_out_mode   = out_mode;
    next_out_adj    = out_adj;
    next_out_phase  = out_phase;
    next_ovr_shadow = ovr_shadow;
    next_ovr_act    = ovr_act;
    next_io_ctl2    = io_ctl2;
    next_io_ctl3    = io_ctl3;
    next_fco_drv    = fco_drv;
    next_dco_drv    = dco_drv;
    if (wr_stb) begin
      case (wr_addr)
        aocr_pkg::ADDR_DEV_INDEX:  next_dev_index = wr_byte;
        aocr_pkg::ADDR_POWER_MODE:
          next_pwr_mode = wr_byte[aocr_pkg::PM_MODE_LSB +: 2];
        aocr_pkg::ADDR_CLK_DIV:
          next_div_ratio = wr_byte[aocr_pkg::CD_RATIO_LSB +: 3];
        aocr_pkg::ADDR_OUT_MODE:   next_out_mode = wr_byte;
        aocr_pkg::ADDR_OUT_ADJUST: begin
          next_out_adj = wr_byte;
          // Drive only lands on clock channels currently selected
          if (dev_index[aocr_pkg::DI_FCO_BIT]) begin
            next_fco_drv = wr_byte[aocr_pkg::OA_DRIVE_BIT];
          end
          if (dev_index[aocr_pkg::DI_DCO_BIT]) begin
            next_dco_drv = wr_byte[aocr_pkg::OA_DRIVE_BIT];
          end
        end
        aocr_pkg::ADDR_OUT_PHASE:  next_out_phase = wr_byte;
        aocr_pkg::ADDR_OVERRIDE:   next_ovr_shadow = wr_byte;
        aocr_pkg::ADDR_TRANSFER: begin
          // Transfer bit is self-clearing and reads back zero
          if (wr_byte[aocr_pkg::XFER_BIT]) begin
            next_ovr_act.enable = ovr_shadow[aocr_pkg::OV_EN_BIT];
            next_ovr_act.res    = ovr_shadow[aocr_pkg::OV_RES_LSB +: 2];
            next_ovr_act.rate   = ovr_shadow[aocr_pkg::OV_RATE_LSB +: 3];
          end
        end
        aocr_pkg::ADDR_USER_IO2:   next_io_ctl2 = wr_byte;
        aocr_pkg::ADDR_USER_IO3:   next_io_ctl3 = wr_byte;
        default: ; // Unmapped writes are dropped
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dev_index  <= aocr_pkg::RST_DEV_INDEX;
      pwr_mode   <= aocr_pkg::PM_NORMAL;
      div_ratio  <= 3'h0;
      out_mode   <= aocr_pkg::RST_OUT_MODE;
      out_adj    <= aocr_pkg::RST_ZERO;
      out_phase  <= aocr_pkg::RST_OUT_PHASE;
      ovr_shadow <= aocr_pkg::RST_ZERO;
      ovr_act    <= '{enable: 1'b0, res: 2'h0, rate: 3'h0};
      io_ctl2    <= aocr_pkg::RST_ZERO;
      io_ctl3    <= aocr_pkg::RST_ZERO;
      fco_drv    <= 1'b0;
      dco_drv    <= 1'b0;
    end else begin
      dev_index  <= next_dev_index;
      pwr_mode   <= next_pwr_mode;
      div_ratio  <= next_div_ratio;
      out_mode   <= next_out_mode;
      out_adj    <= next_out_adj;
      out_phase  <= next_out_phase;
      ovr_shadow <= next_ovr_shadow;
      ovr_act    <= next_ovr_act;
      io_ctl2    <= next_io_ctl2;
      io_ctl3    <= next_io_ctl3;
      fco_drv    <= next_fco_drv;
      dco_drv    <= next_dco_drv;
    end
  end

  // Derived controls
  logic       upgrade;   // Applied override asks for more than the grade
  logic       dig_reset; // Power mode 11
  logic       path_run;  // Data path clocked and out of reset
  logic [2:0] clk_phase;
  logic [DATA_W-1:0] fmt_word;
  assign upgrade = ovr_act.enable &&
                   ((ovr_act.rate > SPEED_RATE) ||
                    (ovr_act.res != aocr_pkg::RES_12_BITS &&
                     ovr_act.res != aocr_pkg::RES_10_BITS));
  assign dig_reset = (pwr_mode == aocr_pkg::PM_DIGRESET);
  assign path_run  = (pwr_mode == aocr_pkg::PM_NORMAL) && !upgrade &&
                     (init_st == aocr_pkg::INIT_DONE);
  assign clk_phase = out_phase[aocr_pkg::OP_CLKPH_LSB +: 3];

  // Offset binary in; twos complement flips the sign bit, then invert
  always_comb begin
    fmt_word = sample_data;
    if (out_mode[aocr_pkg::OM_FORMAT_BIT]) begin
      fmt_word[DATA_W-1] = ~sample_data[DATA_W-1];
    end
    if (ovr_act.enable && ovr_act.res == aocr_pkg::RES_10_BITS) begin
      fmt_word[1:0] = 2'h0; // Reduced resolution drops two LSBs
    end
    if (out_mode[aocr_pkg::OM_INVERT_BIT]) begin
      fmt_word = ~fmt_word;
    end
  end

  // Power-up sequencer; a digital reset re-runs it from the start
  always_comb begin
    next_init_st  = init_st;
    next_init_cnt = init_cnt;
    if (dig_reset) begin
      next_init_st  = aocr_pkg::INIT_RUN;
      next_init_cnt = 7'h00;
    end else begin
      case (init_st)
        aocr_pkg::INIT_RUN: begin
          if (init_cnt == 7'(aocr_pkg::INIT_CYCLES - 1)) begin
            next_init_st = aocr_pkg::INIT_DONE;
          end else begin
            next_init_cnt = init_cnt + 7'h01;
          end
        end
        aocr_pkg::INIT_DONE: next_init_cnt = 7'h00;
        default: next_init_st = aocr_pkg::INIT_RUN;
      endcase
    end
  end

  // Input clock divider and sample capture
  always_comb begin
    next_div_cnt   = div_cnt;
    next_strobe    = 1'b0;
    next_out_valid = 1'b0;
    next_out_data  = out_data;
    if (dig_reset || pwr_mode == aocr_pkg::PM_POWERDOWN || upgrade) begin
      // Data path held in reset; the serial port keeps running
      next_div_cnt  = 3'h0;
      next_out_data = '0;
    end else if (path_run) begin
      next_div_cnt = (div_cnt >= div_ratio) ? 3'h0 : div_cnt + 3'h1;
      // Phase only matters with a divider; without one every cycle samples
      next_strobe = (div_ratio == 3'h0) || (div_cnt == clk_phase);
      if (next_strobe && sample_valid) begin
        next_out_data  = fmt_word;
        next_out_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      init_st       <= aocr_pkg::INIT_RUN;
      init_cnt      <= 7'h00;
      div_cnt       <= 3'h0;
      sample_strobe <= 1'b0;
      out_valid     <= 1'b0;
      out_data      <= '0;
    end else begin
      init_st       <= next_init_st;
      init_cnt      <= next_init_cnt;
      div_cnt       <= next_div_cnt;
      sample_strobe <= next_strobe;
      out_valid     <= next_out_valid;
      out_data      <= next_out_data;
    end
  end

  // Registered pad and status outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      term_sel         <= 2'h0;
      fco_drive_2x     <= 1'b0;
      dco_drive_2x     <= 1'b0;
      dco_phase_code   <= aocr_pkg::DCO_CODE_DFLT;
      sdio_pulldown_en <= 1'b1;
      vcm_powerdown    <= 1'b0;
      res_10bit        <= 1'b0;
      rate_code        <= SPEED_RATE;
      chip_powerdown   <= 1'b0;
      datapath_reset   <= 1'b0;
      datapath_clk_en  <= 1'b0;
      init_done        <= 1'b0;
    end else begin
      term_sel <= out_adj[aocr_pkg::OA_TERM_LSB +: 2];
      // Any termination choice wins over doubled clock drive
      fco_drive_2x <= fco_drv && (out_adj[aocr_pkg::OA_TERM_LSB +: 2]
                                  == 2'h0);
      dco_drive_2x <= dco_drv && (out_adj[aocr_pkg::OA_TERM_LSB +: 2]
                                  == 2'h0);
      // Codes above 660 degrees are undefined; fall back to 180
      dco_phase_code <= (out_phase[aocr_pkg::OP_DCOPH_LSB +: 4] >
                         aocr_pkg::DCO_CODE_MAX) ? aocr_pkg::DCO_CODE_DFLT :
                        out_phase[aocr_pkg::OP_DCOPH_LSB +: 4];
      sdio_pulldown_en <= ~io_ctl2[aocr_pkg::IO2_PD_BIT];
      vcm_powerdown    <= io_ctl3[aocr_pkg::IO3_VCM_BIT];
      res_10bit <= ovr_act.enable &&
                   ovr_act.res == aocr_pkg::RES_10_BITS;
      rate_code <= ovr_act.enable ? ovr_act.rate : SPEED_RATE;
      chip_powerdown  <= upgrade;
      datapath_reset  <= dig_reset || pwr_mode == aocr_pkg::PM_POWERDOWN;
      datapath_clk_en <= path_run;
      init_done       <= (init_st == aocr_pkg::INIT_DONE);
    end
  end

endmodule // aocr_config_regs

// [dv/aocr_config_props.sv]
// Property checker for the output configuration bank
`timescale 1ns/1ps
module aocr_config_props (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Watched ports
  input wire logic       spi_csb_n,
  input wire logic       sample_valid,
  input wire logic       sdio_oe_n,
  input wire logic       out_valid,
  input wire logic [1:0] term_sel,
  input wire logic       fco_drive_2x,
  input wire logic       dco_drive_2x,
  input wire logic [3:0] dco_phase_code,
  input wire logic       sdio_pulldown_en,
  input wire logic       vcm_powerdown,
  input wire logic [2:0] rate_code,
  input wire logic       chip_powerdown,
  input wire logic       datapath_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Cycles since deselect
  logic [4:0] idle_cnt;
  logic [4:0] next_idle_cnt;
  // Next count
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (!spi_csb_n) begin
      next_idle_cnt = 5'h00;
    end else if (idle_cnt != 5'h1F) begin
      next_idle_cnt = idle_cnt + 5'h01;
    end
  end
  // Count register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idle_cnt <= 5'h1F;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end
  chk_term_wins: assert property (term_sel != 2'h0 |->
    !fco_drive_2x && !dco_drive_2x) else $error("drive with termination");
  chk_phase_range: assert property (dco_phase_code <= 4'hB)
    else $error("clock phase code out of range");
  chk_reset_quiet: assert property (datapath_reset |=> !out_valid)
    else $error("output during data path reset");
  chk_down_quiet: assert property (chip_powerdown |=> !out_valid)
    else $error("output while powered down");
  chk_rate_limit: assert property (rate_code > 3'h4 |-> chip_powerdown)
    else $error("upgrade without power-down");
  chk_valid_cause: assert property (out_valid |-> $past(sample_valid))
    else $error("output without sample");
  chk_sdio_release: assert property (spi_csb_n [*8] |-> sdio_oe_n)
    else $error("data pin driven while idle");
  // Config moves only in frames
  chk_cfg_by_write: assert property (($changed(term_sel) ||
    $changed(dco_phase_code) || $changed(vcm_powerdown) ||
    $changed(sdio_pulldown_en)) |-> idle_cnt < 5'h0C)
    else $error("config output moved without write");
  cover property ($rose(chip_powerdown));
  cover property ($rose(fco_drive_2x));
  cover property (!sdio_oe_n);
endmodule // aocr_config_props

bind aocr_config_regs aocr_config_props chk (.clk_sys, .reset, .spi_csb_n,
  .sample_valid, .sdio_oe_n, .out_valid, .term_sel, .fco_drive_2x,
  .dco_drive_2x, .dco_phase_code, .sdio_pulldown_en, .vcm_powerdown,
  .rate_code, .chip_powerdown, .datapath_reset);

// [dv/aocr_host_model.sv]
// Host controller model on the serial configuration port
`timescale 1ns/1ps
module aocr_host_model (
  // Clock
  input  wire logic clk_sys,
  // Device side of the data pin
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  input  wire logic sdio_pulldown_en,
  // Serial pins
  output logic      spi_sclk,
  output logic      spi_csb_n,
  output logic      sdio_in
);
  logic host_en;  // Host drives the data pin
  logic host_d;   // Host data bit
  // Device, host, pull-down, else the inverse
  assign sdio_in = !sdio_oe_n ? sdio_out : host_en ? host_d :
                   sdio_pulldown_en ? 1'b0 : ~host_d;
  // Idle: clock low, select high
  initial begin
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    host_en = 1'b0;
    host_d = 1'b0;
  end
  // Half period, above the glitch filter
  task automatic hold();
    repeat (8) @(negedge clk_sys);
  endtask
  // One frame of one byte
  task automatic xfer(input logic rw, input logic [12:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] w;
    w = {rw, 2'b00, a, d};
    spi_csb_n = 1'b0;
    hold();
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b0;
      host_d = w[i];
      host_en = !(rw && i < 8);
      hold();
      if (i < 8) q[i] = sdio_in;
      spi_sclk = 1'b1;
      hold();
    end
    spi_sclk = 1'b0;
    hold();
    spi_csb_n = 1'b1;
    host_en = 1'b0;
    hold();
  endtask
  // Register write
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask
  // Register read
  task automatic rd(input logic [12:0] a, output logic [7:0] q);
    xfer(1'b1, a, 8'h00, q);
  endtask
endmodule // aocr_host_model

// [dv/test_adc_output_config_regs.sv]
// Self-checking bench for the output configuration bank
`timescale 1ns/1ps
module test_adc_output_config_regs;
  logic clk_sys, reset, sclk, csb_n, sdio_in, sdio_out, oe_n, pd_en;
  logic [11:0] sample_data, out_data;
  logic sample_valid, out_valid, strobe, fco2, dco2, vcm_pd, res10;
  logic chip_pd, dp_rst, init_done;
  logic [1:0] term_sel;
  logic [3:0] dco_ph;
  logic [2:0] rate_code;
  int errors = 0, checks = 0, cyc = 0;
  // Device under test
  aocr_config_regs dut (.clk_sys, .reset, .spi_sclk(sclk),
    .spi_csb_n(csb_n), .sdio_in, .sdio_out, .sdio_oe_n(oe_n),
    .sample_data, .sample_valid, .out_data, .out_valid,
    .sample_strobe(strobe), .term_sel, .fco_drive_2x(fco2),
    .dco_drive_2x(dco2), .dco_phase_code(dco_ph),
    .sdio_pulldown_en(pd_en), .vcm_powerdown(vcm_pd), .res_10bit(res10),
    .rate_code, .chip_powerdown(chip_pd), .datapath_reset(dp_rst),
    .datapath_clk_en(), .init_done);
  // Host on the serial port
  aocr_host_model host (.clk_sys, .sdio_out, .sdio_oe_n(oe_n),
    .sdio_pulldown_en(pd_en), .spi_sclk(sclk), .spi_csb_n(csb_n),
    .sdio_in);
  // Short register names
  localparam logic [12:0] ADJ = aocr_pkg::ADDR_OUT_ADJUST,
    PHS = aocr_pkg::ADDR_OUT_PHASE, OVR = aocr_pkg::ADDR_OVERRIDE,
    XFR = aocr_pkg::ADDR_TRANSFER, MODE = aocr_pkg::ADDR_OUT_MODE,
    IO2 = aocr_pkg::ADDR_USER_IO2, IO3 = aocr_pkg::ADDR_USER_IO3;
  // 50 MHz clock and a free cycle count
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc++;
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the start-up sequencer
  task automatic wait_init();
    int n = 0;
    while (init_done !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 200) begin errors++; stop_test(); end
  endtask
  // Offer a sample until it comes out, then compare it
  task automatic samp(input logic [11:0] v, input logic [11:0] e);
    int n = 0;
    sample_data = v;
    sample_valid = 1'b1;
    @(negedge clk_sys);
    while (out_valid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) begin errors++; stop_test(); end
    check(out_data, e);
    sample_valid = 1'b0;
  endtask
  // Cycle position of the next strobe within an eight cycle period
  task automatic strobe_pos(output int p);
    int n = 0;
    @(negedge clk_sys);
    while (strobe !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 20) begin errors++; stop_test(); end
    p = cyc % 8;
  endtask
  // Read a register and compare it
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.rd(a, q);
    check(q, e);
  endtask
  task automatic t_reset();
    wait_init();
    check(dco_ph, 4'h3);
    check(rate_code, 3'h4);
    check(pd_en, 1'b1);
    rdc(PHS, 8'h03);
    rdc(ADJ, 8'h00);
    rdc(OVR, 8'h00);
    rdc(IO2, 8'h00);
    rdc(IO3, 8'h00);
    $display("reset done");
  endtask
  task automatic t_format();
    samp(12'h123, 12'h923);
    host.wr(MODE, 8'h00);
    samp(12'h123, 12'h123);
    host.wr(MODE, 8'h04);
    samp(12'h123, 12'hEDC);
    host.wr(MODE, 8'h05);
    samp(12'h123, 12'h6DC);
    host.wr(MODE, 8'h01);
    $display("format done");
  endtask
  task automatic t_drive();
    host.wr(aocr_pkg::ADDR_DEV_INDEX, 8'h30);
    host.wr(ADJ, 8'h01);
    check(fco2, 1'b1);
    check(dco2, 1'b1);
    host.wr(ADJ, 8'h21);
    check(term_sel, 2'h2);
    check(fco2, 1'b0);
    check(dco2, 1'b0);
    host.wr(aocr_pkg::ADDR_DEV_INDEX, 8'h10);
    host.wr(ADJ, 8'h00);
    check(fco2, 1'b0);
    check(dco2, 1'b1);
    host.wr(ADJ, 8'h01);
    check(fco2, 1'b1);
    $display("drive done");
  endtask
  task automatic t_phase();
    int p0, p1;
    for (int c = 0; c < 13; c++) begin
      host.wr(PHS, 8'(c));
      check(dco_ph, (c > 11) ? 12'h3 : 12'(c));
    end
    // Strobe position moves with the clock phase field under divider ratio 7
    host.wr(aocr_pkg::ADDR_CLK_DIV, 8'h07);
    host.wr(PHS, 8'h33);
    strobe_pos(p0);
    host.wr(PHS, 8'h53);
    strobe_pos(p1);
    check(12'((p1 - p0 + 8) % 8), 12'h2);
    host.wr(PHS, 8'h03);
    host.wr(aocr_pkg::ADDR_CLK_DIV, 8'h00);
    $display("phase done");
  endtask
  task automatic t_override();
    host.wr(OVR, 8'h74);
    check(res10, 1'b0);
    host.wr(XFR, 8'h01);
    check(res10, 1'b1);
    check(chip_pd, 1'b0);
    samp(12'h123, 12'h920);
    host.wr(OVR, 8'h45);
    check(chip_pd, 1'b0);
    host.wr(XFR, 8'h01);
    check(chip_pd, 1'b1);
    host.wr(OVR, 8'h00);
    host.wr(XFR, 8'h01);
    check(chip_pd, 1'b0);
    check(rate_code, 3'h4);
    $display("override done");
  endtask
  task automatic t_io();
    host.wr(IO2, 8'h01);
    check(pd_en, 1'b0);
    host.wr(IO3, 8'h08);
    check(vcm_pd, 1'b1);
    rdc(IO3, 8'h08);
    rdc(13'h0050, 8'h00);
    host.wr(IO2, 8'h00);
    check(pd_en, 1'b1);
    $display("io done");
  endtask
  task automatic t_digreset();
    host.wr(aocr_pkg::ADDR_POWER_MODE, 8'h03);
    check(dp_rst, 1'b1);
    rdc(ADJ, 8'h01);
    host.wr(aocr_pkg::ADDR_POWER_MODE, 8'h00);
    check(dp_rst, 1'b0);
    check(init_done, 1'b0);
    wait_init();
    samp(12'h123, 12'h923);
    $display("digital reset done");
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    sample_data = 12'h000;
    sample_valid = 1'b0;
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    t_reset();
    t_format();
    t_drive();
    t_phase();
    t_override();
    t_io();
    t_digreset();
    stop_test();
  end
endmodule // test_adc_output_config_regs
